/* hdl/pssp_cfg.svh */
`ifndef PSSP_CFG_SVH
`define PSSP_CFG_SVH
// read latency in enabled cycles from command to data on the bus
`define PSSP_READ_LATENCY 2
// write data follows its command by the same distance
`define PSSP_WRITE_LATENCY 2
// burst counter width, four beats per burst
`define PSSP_BURST_BITS 2
// organisation select codes
`define PSSP_ORG_WIDE 1'b1
`define PSSP_ORG_NARROW 1'b0
`endif

/* hdl/pssp_pkg.sv */
package pssp_pkg;
  // command decoded at the input registers
  typedef enum logic [2:0]
  {
    PSSP_IDLE = 3'b001,
    PSSP_READ = 3'b010,
    PSSP_WRITE = 3'b100
  } pssp_cmd_t;
  // one pipeline stage entry
  typedef struct packed
  {
    logic valid;
    logic isWrite;
    logic [18:0] addr;
    logic [3:0] laneN;
  } pssp_stage_t;
endpackage

/* hdl/pssp_mem.sv */
`timescale 1ns/1ps
// storage array with byte-lane writes and registered read data
module pssp_mem #(
  parameter int ADDR_W = 18,
  parameter int LANES = 4,
  parameter int LANE_W = 9
) (
  input wire logic clk,
  input wire logic en,
  input wire logic wrEn,
  input wire logic [LANES-1:0] laneN,
  input wire logic [ADDR_W-1:0] wrAddr,
  input wire logic [LANES*LANE_W-1:0] wrData,
  input wire logic rdEn,
  input wire logic [ADDR_W-1:0] rdAddr,
  output logic [LANES*LANE_W-1:0] rdData
);
  logic [LANES*LANE_W-1:0] mem [0:(1<<ADDR_W)-1];
  // self-timed write, all selected lanes in the same cycle
  always_ff @(posedge clk)
  begin
    if (en && wrEn)
    begin
      for (int i = 0; i < LANES; i++)
      begin
        if (!laneN[i])
          mem[wrAddr][i*LANE_W +: LANE_W] <= wrData[i*LANE_W +: LANE_W];
      end
    end
  end
  // read word lands in a register
  always_ff @(posedge clk)
  begin
    if (en && rdEn)
      rdData <= mem[rdAddr];
  end
endmodule

/* hdl/pssp_port.sv */
`timescale 1ns/1ps
`include "pssp_cfg.svh"
// ****************************************************************
// Summary of operation
// - all inputs except output enable and reset captured on rising edge
// - read data leaves through output registers
// - deasserted clock qualifier freezes everything
// - drivers off while write data presented
// - new read or write every enabled clock
// - one word per cycle, no turnaround
// - 256K x 36 or 512K x 18
// - self-timed writes on selected byte lanes
// - three chip selects, async output enable
// - output buffers controlled internally
// - linear or interleaved burst order
// ****************************************************************
module pssp_port
  import pssp_pkg::*;
#(
  parameter bit WIDE = `PSSP_ORG_WIDE,
  parameter int LANES = WIDE ? 4 : 2,
  parameter int DW = LANES * 9,
  parameter int AW = WIDE ? 18 : 19
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clock_qualify_n,
  input wire logic chip_select_first_n,
  input wire logic chip_select_second,
  input wire logic chip_select_third_n,
  input wire logic writeStrobe_n,
  input wire logic burstAdvance,
  input wire logic interleaveMode,
  input wire logic outputEnable_n,
  input wire logic [LANES-1:0] byte_lane_write_n,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] dataIn,
  output logic [DW-1:0] dataOut,
  output logic dataOe
);
  import pssp_pkg::*;
  // ****************************************************************
  // input stage
  // ****************************************************************
  wire logic en = !clock_qualify_n;
  wire logic sel = !chip_select_first_n && chip_select_second && !chip_select_third_n;
  pssp_cmd_t cmdIn;
  pssp_stage_t s0_r, s1_r; // two-stage command pipe
  pssp_stage_t s0_nxt;
  logic [AW-1:0] baseAddr_r; // burst base address
  logic [`PSSP_BURST_BITS-1:0] beat_r; // burst counter
  logic lastWrite_r; // kind of last loaded command
  logic [3:0] lastLane_r;
  logic readOut_r; // read data valid at array read register
  logic [DW-1:0] wrData_r; // write data input register
  logic [AW-1:0] burstAddr;
  logic [`PSSP_BURST_BITS-1:0] lowBits;
  // continuation beat uses linear add or xor interleave
  assign lowBits = interleaveMode ? (baseAddr_r[`PSSP_BURST_BITS-1:0] ^ beat_r)
                                  : (baseAddr_r[`PSSP_BURST_BITS-1:0] + beat_r);
  assign burstAddr = {baseAddr_r[AW-1:`PSSP_BURST_BITS], lowBits};
  // decode new command; advance reuses previous kind
  assign cmdIn = burstAdvance ? (lastWrite_r ? PSSP_WRITE : PSSP_READ)
               : !sel ? PSSP_IDLE : (writeStrobe_n ? PSSP_READ : PSSP_WRITE);
  always_comb
  begin
    s0_nxt = '0;
    s0_nxt.valid = (cmdIn != PSSP_IDLE);
    s0_nxt.isWrite = (cmdIn == PSSP_WRITE);
    s0_nxt.addr = 19'(burstAdvance ? burstAddr : addr);
    s0_nxt.laneN = 4'(byte_lane_write_n) | (WIDE ? 4'h0 : 4'hC);
    if (burstAdvance)
      s0_nxt.laneN = lastLane_r;
  end
  // command capture on enabled rising edges only
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s0_r <= '0;
      s1_r <= '0;
      baseAddr_r <= '0;
      beat_r <= '0;
      lastWrite_r <= 1'b0;
      lastLane_r <= 4'hF;
    end
    else if (en)
    begin
      s0_r <= s0_nxt;
      s1_r <= s0_r;
      if (!burstAdvance && sel)
      begin
        baseAddr_r <= addr;
        beat_r <= 2'h1;
        lastWrite_r <= !writeStrobe_n;
        lastLane_r <= s0_nxt.laneN;
      end
      else if (burstAdvance)
        beat_r <= beat_r + 2'h1;
    end
  end
  // write data sampled as the write leaves its second stage
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      wrData_r <= '0;
    else if (en)
      wrData_r <= dataIn;
  end
  // ****************************************************************
  // array and output stage
  // ****************************************************************
  logic memWr_r; // write committed one cycle after data capture
  logic [AW-1:0] memWrAddr_r;
  logic [LANES-1:0] memLane_r;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      memWr_r <= 1'b0;
      memWrAddr_r <= '0;
      memLane_r <= '1;
    end
    else if (en)
    begin
      memWr_r <= s1_r.valid && s1_r.isWrite;
      memWrAddr_r <= AW'(s1_r.addr);
      memLane_r <= LANES'(s1_r.laneN);
    end
  end
  // read after a just-captured write needs bypass: array write lags
  wire logic rdHit = memWr_r && (memWrAddr_r == AW'(s0_r.addr));
  logic [DW-1:0] arrayOut;
  logic bypass_r;
  logic [DW-1:0] byWord_r;
  logic [LANES-1:0] byLane_r;
  pssp_mem #(.ADDR_W(AW), .LANES(LANES), .LANE_W(9)) uMem (
    .clk(clk),
    .en(en),
    .wrEn(memWr_r),
    .laneN(memLane_r),
    .wrAddr(memWrAddr_r),
    .wrData(wrData_r),
    .rdEn(s0_r.valid && !s0_r.isWrite),
    .rdAddr(AW'(s0_r.addr)),
    .rdData(arrayOut)
  );
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bypass_r <= 1'b0;
      byWord_r <= '0;
      byLane_r <= '1;
      readOut_r <= 1'b0;
    end
    else if (en)
    begin
      bypass_r <= rdHit;
      byWord_r <= wrData_r;
      byLane_r <= memLane_r;
      readOut_r <= s0_r.valid && !s0_r.isWrite;
    end
  end
  // write issued one slot before the read: its data only lands as the read leaves
  wire logic lateHit = memWr_r && (memWrAddr_r == AW'(s1_r.addr));
  // merge pending write lanes into read word
  logic [DW-1:0] merged;
  always_comb
  begin
    merged = arrayOut;
    for (int i = 0; i < LANES; i++)
    begin
      if (bypass_r && !byLane_r[i])
        merged[i*9 +: 9] = byWord_r[i*9 +: 9];
      // newer write wins over the older one
      if (lateHit && !memLane_r[i])
        merged[i*9 +: 9] = wrData_r[i*9 +: 9];
    end
  end
  // output register, updated only on enabled edges
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      dataOut <= '0;
    else if (en)
      dataOut <= merged;
  end
  // drivers on only in read data slots; write slots stay off
  logic drive_r;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      drive_r <= 1'b0;
    else if (en)
      drive_r <= readOut_r;
  end
  assign dataOe = drive_r && !outputEnable_n;
  // ****************************************************************
  // checks
  // ****************************************************************
  sequence readIssued;
    en && sel && !burstAdvance && writeStrobe_n;
  endsequence
  // two enabled edges in a row carry a command to the output stage
  sequence twoEnabled;
    en ##1 en;
  endsequence
  // read leaving while the write just before it is still in flight
  sequence lateReadHit;
    en && lateHit && s1_r.valid && !s1_r.isWrite && !memLane_r[0];
  endsequence
  a_read_drive: assert property (@(posedge clk) disable iff (rst)
    readIssued ##1 twoEnabled |=> drive_r) else $error("read slot not driven");
  a_write_quiet: assert property (@(posedge clk) disable iff (rst)
    (s1_r.valid && s1_r.isWrite && en) |=> !dataOe) else $error("drive in write slot");
  a_freeze_out: assert property (@(posedge clk) disable iff (rst)
    !en |=> $stable(dataOut) && $stable(s0_r)) else $error("state moved while stalled");
  a_oe_gate: assert property (@(posedge clk) disable iff (rst)
    outputEnable_n |-> !dataOe) else $error("drive with enable off");
  a_cmd_take: assert property (@(posedge clk) disable iff (rst)
    (en && sel && !burstAdvance) |=> s0_r.valid) else $error("command dropped");
  a_pipe_move: assert property (@(posedge clk) disable iff (rst)
    en |=> s1_r == $past(s0_r)) else $error("pipe stalled");
  a_input_reg: assert property (@(posedge clk) disable iff (rst)
    (en && sel && !burstAdvance) |=> s0_r.addr == 19'($past(addr))) else $error("addr lost");
  a_out_reg: assert property (@(posedge clk) disable iff (rst)
    en |=> dataOut == $past(merged)) else $error("output not registered");
  a_late_merge: assert property (@(posedge clk) disable iff (rst)
    lateReadHit |=> dataOut[8:0] == $past(wrData_r[8:0])) else $error("late write lost");
endmodule

/* verif/pssp_host.sv */
`timescale 1ns/1ps
// ****
// host side of the bus
// ****
module pssp_host
(
  input wire logic clk,
  output logic qn,
  output logic [2:0] cs,
  output logic wrN,
  output logic adv,
  output logic [3:0] laneN,
  output logic [17:0] a,
  output logic [35:0] d
);
  import pssp_pkg::*;
  logic [36:0] pipe[$]; // write data waits two slots
  logic [36:0] t;
  initial
  begin
    qn = 1'b1;
    {cs, wrN, adv, laneN, a, d} = '0;
  end
  // one slot, driven after the falling edge
  task automatic go(input logic [27:0] c, input logic [36:0] wv);
    @(negedge clk);
    {qn, cs, wrN, adv, laneN, a} <= c;
    // a frozen slot keeps the data lines as they were
    if (!c[27])
    begin
      pipe.push_back(wv);
      t = pipe.size() > 2 ? pipe.pop_front() : 37'h0;
      // no write due: keep the line moving
      d <= t[36] ? t[35:0] : ~d;
    end
  endtask
endmodule

/* verif/pssp_port_tb.sv */
`timescale 1ns/1ps
// ****
// scoreboard bench
// ****
module pssp_port_tb;
  import pssp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic oeN = 1'b0;
  logic ilv = 1'b0;
  logic qn, wrN, adv, dataOe, bw, act = 1'b0;
  logic [2:0] cs;
  logic [3:0] laneN, base, bl;
  logic [1:0] k;
  logic [17:0] a;
  logic [35:0] d, dataOut, last;
  logic [35:0] mem[16]; // reference array
  logic [36:0] notes[$]; // expected {drive, data} per slot
  logic [31:0] r, seed = 32'h00015ABB;
  int errors = 0;
  int samples_checked = 0;
  always #10 clk = ~clk;
  pssp_host pssp_host_inst (.clk(clk), .qn(qn), .cs(cs), .wrN(wrN), .adv(adv),
    .laneN(laneN), .a(a), .d(d));
  pssp_port pssp_port_inst (.clk(clk), .rst(rst), .clock_qualify_n(qn),
    .chip_select_first_n(cs[0]), .chip_select_second(cs[1]),
    .chip_select_third_n(cs[2]), .writeStrobe_n(wrN), .burstAdvance(adv),
    .interleaveMode(ilv), .outputEnable_n(oeN), .byte_lane_write_n(laneN),
    .addr(a), .dataIn(d), .dataOut(dataOut), .dataOe(dataOe));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (!ok)
    begin
      errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // one slot: model update, then note for the pipeline
  task automatic op(input logic q, input logic [2:0] c, input logic w, input logic v,
    input logic [3:0] l, input logic [3:0] ad, input logic [35:0] dt);
    logic [3:0] ea;
    logic go;
    go = !q && (c == 3'b010 || v);
    if (go && !v)
    begin
      base = ad;
      bl = l;
      k = 2'h0;
      bw = !w;
    end
    else if (go)
      k = k + 2'h1;
    ea = {base[3:2], ilv ? base[1:0] ^ k : base[1:0] + k};
    pssp_host_inst.go({q, c, w, v, l, 14'h0, ad}, {go && bw, dt});
    for (int i = 0; i < 4; i++)
      if (go && bw && !bl[i]) mem[ea][i*9+:9] = dt[i*9+:9];
    if (!q) notes.push_back({go && !bw, mem[ea]});
    act = q ? act : go;
  endtask
  // watcher: one note per enabled edge, after two in flight
  always @(posedge clk)
  begin
    logic q;
    logic [36:0] n;
    q = qn;
    #2;
    if (!rst && q) chk(dataOut === last, "frozen output moved");
    else if (!rst && notes.size() > 2)
    begin
      n = notes.pop_front();
      chk(dataOe === (n[36] && !oeN), "drive enable");
      if (n[36] && !oeN) chk(dataOut === n[35:0], "read data");
    end
    last = dataOut;
  end
  initial
  begin
    #32 chk(dataOut === 36'h0 && dataOe === 1'b0, "reset value");
    @(negedge clk) rst = 1'b0;
    $display("test reset done");
    for (int i = 0; i < 16; i++) op(0, 3'b010, 0, 0, 4'h0, i[3:0], {rnd(), 4'h5});
    for (int i = 0; i < 3; i++) op(0, 3'b010 ^ (3'b001 << i), 1, 0, 4'h0, 4'h1, 36'h0);
    $display("test fill done");
    // random mix, outputs gated off briefly, order mode swapped midway
    for (int i = 0; i < 400; i++)
    begin
      r = rnd();
      oeN = i inside {[100:103]};
      ilv = i >= 200;
      // the order strap reaches the pins one slot early: no burst step across the switch
      op(r[2:0] == 3'h0, r[4:3] == 2'h0 ? r[9:7] : 3'b010, r[5],
        act && r[6] && k != 2'h3 && i != 199, r[13:10], r[17:14], {rnd(), r[31:28]});
    end
    repeat (3) op(0, 3'b000, 1, 0, 4'hF, 4'h0, 36'h0);
    repeat (2) @(negedge clk);
    $display("test random done");
    end_of_test();
  end
  initial
  begin
    #50us;
    errors++;
    end_of_test();
  end
endmodule
